/* File: common/mhp_cfg.svh */
`ifndef MHP_CFG_SVH
`define MHP_CFG_SVH
// Port offsets within the two-byte window.
`define MHP_OFS_DATA    1'h0
`define MHP_OFS_CMD     1'h1
// Number of compared address bits; all bits above must be zero.
`define MHP_ADDR_BITS   10
// Status bit positions.
`define MHP_STAT_RXE    7
`define MHP_STAT_TXF    6
// Command codes and answers.
`define MHP_CMD_UART    8'h3f
`define MHP_CMD_RESET   8'hff
`define MHP_CMD_AX_HI   5'h14
`define MHP_CMD_AB      8'hab
`define MHP_CMD_AC      8'hac
`define MHP_CMD_AD      8'had
`define MHP_CMD_AF      8'haf
`define MHP_ACK         8'hfe
`define MHP_RSP_AX      8'h00
`define MHP_RSP_AC      8'h15
`define MHP_RSP_AD      8'h01
`define MHP_RSP_AF      8'h64
// Timing: clock rate and line rate in hertz, then derived cycle counts.
`define MHP_CLK_HZ      40000000
`define MHP_BAUD_HZ     31250
`define MHP_OVS         16
`define MHP_BIT_CYC     (`MHP_CLK_HZ / `MHP_BAUD_HZ)
`define MHP_TICK_CYC    (`MHP_BIT_CYC / `MHP_OVS)
`define MHP_FIFO_DEPTH  16
`endif

/* File: common/mhp_pkg.sv */
`default_nettype none
package mhp_pkg;
    // Receiver states, Gray coded along the frame.
    typedef enum logic [1:0] {
        MHP_RX_IDLE  = 2'h0,
        MHP_RX_START = 2'h1,
        MHP_RX_DATA  = 2'h3,
        MHP_RX_STOP  = 2'h2
    } mhp_rx_st_type;

    typedef struct packed {
        logic          s1;
        logic          s2;
        mhp_rx_st_type st;
        logic [6:0]    tick;
        logic [3:0]    nt;
        logic [2:0]    nbit;
        logic [7:0]    shift;
        logic          valid;
        logic [7:0]    data;
    } mhp_rx_state_type;

    typedef struct packed {
        logic [15:0] sa_s1;
        logic [15:0] sa_s2;
        logic        aen_s1;
        logic        aen_s2;
        logic        iow_s1;
        logic        iow_s2;
        logic        iow_d;
        logic        ior_s1;
        logic        ior_s2;
        logic        ior_d;
        logic [7:0]  sd_s1;
        logic [7:0]  sd_s2;
        logic        wr_hit;
        logic        wr_ofs;
        logic [7:0]  wr_data;
        logic        rd_act;
        logic        rd_ofs;
        logic        uart;
        logic [5:0]  last_cmd;
        logic        ack_pend;
        logic [7:0]  ack_byte;
        logic        ack2_pend;
        logic [7:0]  ack2_byte;
        logic        rx_pend;
        logic [7:0]  rx_byte;
        logic [7:0]  last_rd;
        logic        irq;
        logic [7:0]  sd_out;
        logic        sd_oe;
        logic        tx_busy;
        logic [9:0]  tx_shift;
        logic [3:0]  tx_bits;
        logic [11:0] tx_baud;
        logic        tx_line;
    } mhp_port_state_type;
endpackage
`default_nettype wire

/* File: hw/mhp_fifo.sv */
`default_nettype none
// Byte FIFO; a push into a full FIFO with no pop in the same cycle replaces the newest entry.
module mhp_fifo
    import mhp_pkg::*;
#(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         clock_in,
    input  wire logic         rstn_in,
    input  wire logic         push_in,
    input  wire logic [W-1:0] push_data_in,
    input  wire logic         pop_in,
    output logic [W-1:0]      head_out,
    output logic              full_out,
    output logic              empty_out
);
    localparam int AW = $clog2(D);
    localparam int CW = AW + 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       rd;
        logic [AW-1:0]       wr;
        logic [AW:0]         cnt;
    } mhp_fifo_state_type;

    mhp_fifo_state_type s;
    mhp_fifo_state_type n;
    logic               do_pop;
    logic               grow;

    assign head_out  = s.mem[s.rd];
    assign full_out  = (s.cnt == CW'(D));
    assign empty_out = (s.cnt == '0);

    // Pointer and count update; overwrite keeps the newest byte.
    always_comb begin
        n      = s;
        do_pop = pop_in && !empty_out;
        grow   = push_in && !(full_out && !do_pop);
        if (do_pop) begin
            n.rd = AW'(s.rd + 1'b1);
        end
        if (push_in && !grow) begin
            n.mem[AW'(s.wr - 1'b1)] = push_data_in;
        end else if (grow) begin
            n.mem[s.wr] = push_data_in;
            n.wr        = AW'(s.wr + 1'b1);
        end
        n.cnt = CW'(s.cnt + CW'(grow) - CW'(do_pop));
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    AST_FIFO_OVW: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (full_out && push_in && !pop_in) |=> (full_out && head_out == $past(head_out)))
        else $error("Full FIFO changed size or head on overwrite.");
    AST_FIFO_PUSH: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (empty_out && push_in) |=> (!empty_out && head_out == $past(push_data_in)))
        else $error("Push into empty FIFO not visible at head.");
endmodule // mhp_fifo
`default_nettype wire

/* File: hw/mhp_uart_rx.sv */
`default_nettype none
`include "mhp_cfg.svh"
// Serial receiver, 16 ticks per bit, one-cycle byte pulse.
module mhp_uart_rx
    import mhp_pkg::*;
#(
    parameter int TICK_CYC = `MHP_TICK_CYC
) (
    input  wire logic  clock_in,
    input  wire logic  rstn_in,
    input  wire logic  line_in,
    output logic       valid_out,
    output logic [7:0] data_out
);
    mhp_rx_state_type s;
    mhp_rx_state_type n;
    logic             tick;

    assign valid_out = s.valid;
    assign data_out  = s.data;

    // Ticks restart at the falling edge so that the centres line up.
    always_comb begin
        n       = s;
        n.s1    = line_in;
        n.s2    = s.s1;
        n.valid = 1'b0;
        tick    = (s.tick == 7'(TICK_CYC - 1));
        n.tick  = tick ? 7'h00 : 7'(s.tick + 1'b1);
        if (tick) begin
            n.nt = 4'(s.nt + 1'b1);
        end
        unique case (s.st)
            MHP_RX_IDLE: begin
                n.tick = 7'h00;
                n.nt   = 4'h0;
                if (!s.s2) begin
                    n.st = MHP_RX_START;
                end
            end
            MHP_RX_START: begin
                if (tick && s.nt == 4'h7) begin
                    n.nt   = 4'h0;
                    n.nbit = 3'h0;
                    n.st   = s.s2 ? MHP_RX_IDLE : MHP_RX_DATA;
                end
            end
            MHP_RX_DATA: begin
                if (tick && s.nt == 4'hf) begin
                    n.shift = {s.s2, s.shift[7:1]};
                    n.nbit  = 3'(s.nbit + 1'b1);
                    if (s.nbit == 3'h7) begin
                        n.st = MHP_RX_STOP;
                    end
                end
            end
            MHP_RX_STOP: begin
                if (tick && s.nt == 4'hf) begin
                    n.st    = MHP_RX_IDLE;
                    n.valid = s.s2;
                    n.data  = s.shift;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s <= '{s1: 1'b1, s2: 1'b1, st: MHP_RX_IDLE, default: '0};
        end else begin
            s <= n;
        end
    end

    AST_RX_PULSE: assert property (@(posedge clock_in) disable iff (!rstn_in)
        valid_out |=> !valid_out [*8])
        else $error("Receive pulse longer than one cycle.");
endmodule // mhp_uart_rx
`default_nettype wire

/* File: hw/mhp_midi_port.sv */
`default_nettype none
`include "mhp_cfg.svh"

// Functional notes
// - Two locations decoded on ten address bits; higher bits must be zero.
// - Offset zero is data in and out; offset one is command and status.
// - Offset one writes are commands; offset one reads return status.
// - Separate sixteen-byte FIFOs buffer transmit and receive bytes.
// - Any byte placed in the receive FIFO raises the interrupt.
// - Each command write outside UART mode queues an acknowledge byte; in UART mode only FF does.
// - Status bits five to zero echo the last command written.
// - Status bit six reads one while the transmit FIFO is full.
// - Status bit seven reads one while the receive FIFO is empty.
// - In UART mode serial bytes and acknowledges both fill the receive FIFO.
// - Reading the data port clears the interrupt.
// - Line rate is 31.25 kbaud taken from the device clock.
// - Frames are one start, eight data and one stop bit.
// - Start in non-UART mode; data writes ignored, reads give last byte.
// - Command 3F enters UART mode and queues FE.
// - Command FF leaves UART mode; other commands in UART mode only update the status echo.
// - A serial byte into a full receive FIFO replaces its newest entry, unless a data read pops it in the same cycle.
module mhp_midi_port
    import mhp_pkg::*;
#(
    parameter int BIT_CYC  = `MHP_BIT_CYC,
    parameter int TICK_CYC = `MHP_TICK_CYC,
    parameter int DEPTH    = `MHP_FIFO_DEPTH
) (
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    input  wire logic [9:0]  midi_port_base_in,
    input  wire logic [15:0] isa_sa_in,
    input  wire logic        isa_aen_in,
    input  wire logic        isa_iow_n_in,
    input  wire logic        isa_ior_n_in,
    input  wire logic [7:0]  isa_sd_in,
    output logic [7:0]       isa_sd_out,
    output logic             isa_sd_oe_out,
    output logic             isa_irq_out,
    input  wire logic        midi_serial_in,
    output logic             midi_serial_out,
    output logic             uart_mode_out
);
    // ------------------------------------------------------------------
    // State and wiring
    // ------------------------------------------------------------------
    localparam mhp_port_state_type RST = '{
        iow_s1: 1'b1, iow_s2: 1'b1, iow_d: 1'b1,
        ior_s1: 1'b1, ior_s2: 1'b1, ior_d: 1'b1,
        aen_s1: 1'b1, aen_s2: 1'b1, tx_line: 1'b1,
        default: '0
    };

    mhp_port_state_type s;
    mhp_port_state_type n;

    logic       hit;
    logic       wr_evt;
    logic       rd_start;
    logic       rd_end;
    logic       rx_push;
    logic [7:0] rx_push_data;
    logic       rx_pop;
    logic [7:0] rx_head;
    logic       rx_full;
    logic       rx_empty;
    logic       tx_push;
    logic       tx_pop;
    logic [7:0] tx_head;
    logic       tx_full;
    logic       tx_empty;
    logic       ser_valid;
    logic [7:0] ser_data;
    logic [7:0] status;

    // Every top-level output is a flop of the state record.
    assign isa_sd_out      = s.sd_out;
    assign isa_sd_oe_out   = s.sd_oe;
    assign isa_irq_out     = s.irq;
    assign midi_serial_out = s.tx_line;
    assign uart_mode_out   = s.uart;

    // ------------------------------------------------------------------
    // Buffers and receiver
    // ------------------------------------------------------------------
    // receive buffer
    mhp_fifo #(.W(8), .D(DEPTH)) u_rx_fifo (
        .clock_in     (clock_in),
        .rstn_in      (rstn_in),
        .push_in      (rx_push),
        .push_data_in (rx_push_data),
        .pop_in       (rx_pop),
        .head_out     (rx_head),
        .full_out     (rx_full),
        .empty_out    (rx_empty)
    );

    mhp_fifo #(.W(8), .D(DEPTH)) u_tx_fifo (
        .clock_in     (clock_in),
        .rstn_in      (rstn_in),
        .push_in      (tx_push),
        .push_data_in (s.wr_data),
        .pop_in       (tx_pop),
        .head_out     (tx_head),
        .full_out     (tx_full),
        .empty_out    (tx_empty)
    );

    mhp_uart_rx #(.TICK_CYC(TICK_CYC)) u_rx (
        .clock_in  (clock_in),
        .rstn_in   (rstn_in),
        .line_in   (midi_serial_in),
        .valid_out (ser_valid),
        .data_out  (ser_data)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // The bus strobes are asynchronous to this clock, so address, data
    // and strobes all pass two flops; edges are taken on the second.
    always_comb begin
        n         = s;
        n.sa_s1   = isa_sa_in;
        n.sa_s2   = s.sa_s1;
        n.aen_s1  = isa_aen_in;
        n.aen_s2  = s.aen_s1;
        n.iow_s1  = isa_iow_n_in;
        n.iow_s2  = s.iow_s1;
        n.iow_d   = s.iow_s2;
        n.ior_s1  = isa_ior_n_in;
        n.ior_s2  = s.ior_s1;
        n.ior_d   = s.ior_s2;
        n.sd_s1   = isa_sd_in;
        n.sd_s2   = s.sd_s1;
        rx_push      = 1'b0;
        rx_push_data = s.ack_byte;
        rx_pop       = 1'b0;
        tx_push      = 1'b0;
        tx_pop       = 1'b0;

        hit = !s.aen_s2 && (s.sa_s2[15:`MHP_ADDR_BITS] == '0)
              && (s.sa_s2[`MHP_ADDR_BITS-1:1] == midi_port_base_in[`MHP_ADDR_BITS-1:1]);

        status = {rx_empty, tx_full, s.last_cmd};

        // Address and data are held while the write strobe is low, so the
        // values kept are those present just before the trailing edge.
        if (!s.iow_s2) begin
            n.wr_hit  = hit;
            n.wr_ofs  = s.sa_s2[0];
            n.wr_data = s.sd_s2;
        end
        wr_evt   = s.iow_s2 && !s.iow_d && s.wr_hit;
        rd_start = !s.ior_s2 && s.ior_d && hit;
        rd_end   = s.ior_s2 && !s.ior_d && s.rd_act;

        // Queued acknowledges go first; a serial byte waits in rx_byte until none is pending.
        if (s.ack_pend) begin
            rx_push     = 1'b1;
            n.ack_pend  = s.ack2_pend;
            n.ack_byte  = s.ack2_byte;
            n.ack2_pend = 1'b0;
        end else if (s.rx_pend) begin
            rx_push      = 1'b1;
            rx_push_data = s.rx_byte;
            n.rx_pend    = 1'b0;
        end
        if (ser_valid && s.uart) begin
            n.rx_pend = 1'b1;
            n.rx_byte = ser_data;
        end

        if (wr_evt && s.wr_ofs == `MHP_OFS_DATA) begin
            tx_push = s.uart && !tx_full;
        end

        if (wr_evt && s.wr_ofs == `MHP_OFS_CMD) begin
            n.last_cmd = s.wr_data[5:0];
            if (!s.uart) begin
                n.ack_pend = 1'b1;
                n.ack_byte = `MHP_ACK;
                if (s.wr_data == `MHP_CMD_UART) begin
                    n.uart = 1'b1;
                end else if (s.wr_data[7:3] == `MHP_CMD_AX_HI
                             || s.wr_data == `MHP_CMD_AB) begin
                    n.ack2_pend = 1'b1;
                    n.ack2_byte = `MHP_RSP_AX;
                end else if (s.wr_data == `MHP_CMD_AC) begin
                    n.ack2_pend = 1'b1;
                    n.ack2_byte = `MHP_RSP_AC;
                end else if (s.wr_data == `MHP_CMD_AD) begin
                    n.ack2_pend = 1'b1;
                    n.ack2_byte = `MHP_RSP_AD;
                end else if (s.wr_data == `MHP_CMD_AF) begin
                    n.ack2_pend = 1'b1;
                    n.ack2_byte = `MHP_RSP_AF;
                end
            end else if (s.wr_data == `MHP_CMD_RESET) begin
                n.uart     = 1'b0;
                n.ack_pend = 1'b1;
                n.ack_byte = `MHP_ACK;
            end
        end

        // Read data is frozen at the leading edge of the strobe.
        if (rd_start) begin
            n.rd_act = 1'b1;
            n.rd_ofs = s.sa_s2[0];
            n.sd_oe  = 1'b1;
            if (s.sa_s2[0] == `MHP_OFS_CMD) begin
                n.sd_out = status;
            end else begin
                n.sd_out = rx_empty ? s.last_rd : rx_head;
            end
        end

        // The byte is consumed only at the trailing edge of the strobe.
        if (rd_end) begin
            n.rd_act = 1'b0;
            n.sd_oe  = 1'b0;
            if (s.rd_ofs == `MHP_OFS_DATA) begin
                n.irq = 1'b0;
                if (!rx_empty) begin
                    rx_pop    = 1'b1;
                    n.last_rd = rx_head;
                end
            end
        end
        if (rx_push) begin
            n.irq = 1'b1;
        end

        if (!s.tx_busy) begin
            if (!tx_empty) begin
                tx_pop     = 1'b1;
                n.tx_busy  = 1'b1;
                n.tx_shift = {1'b1, tx_head, 1'b0};
                n.tx_bits  = 4'h0;
                n.tx_baud  = 12'h000;
            end
        end else if (s.tx_baud == 12'(BIT_CYC - 1)) begin
            n.tx_baud  = 12'h000;
            n.tx_shift = {1'b1, s.tx_shift[9:1]};
            n.tx_bits  = 4'(s.tx_bits + 1'b1);
            if (s.tx_bits == 4'h9) begin
                n.tx_busy = 1'b0;
            end
        end else begin
            n.tx_baud = 12'(s.tx_baud + 1'b1);
        end
        n.tx_line = n.tx_busy ? n.tx_shift[0] : 1'b1;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s <= RST;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_DECODE: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (s.iow_s2 && !s.iow_d && !s.wr_hit) |-> (!tx_push ##1 $stable(s.uart)))
        else $error("Write outside the decoded window had an effect.");
    AST_STAT_FLAGS: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (rd_start && s.sa_s2[0]) |=> (isa_sd_out[7:6] == {$past(rx_empty), $past(tx_full)}))
        else $error("Status flags wrong.");
    AST_STAT_ECHO: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (rd_start && s.sa_s2[0]) |=> (isa_sd_out[5:0] == $past(s.last_cmd) && isa_sd_oe_out))
        else $error("Status does not echo the last command.");
    AST_IRQ_SET: assert property (@(posedge clock_in) disable iff (!rstn_in)
        rx_push |=> isa_irq_out)
        else $error("Interrupt not raised on receive insertion.");
    AST_IRQ_CLR: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (rd_end && !s.rd_ofs && !rx_push) |=> !isa_irq_out)
        else $error("Data read did not clear the interrupt.");
    AST_UART_ON: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (wr_evt && s.wr_ofs && !s.uart && s.wr_data == `MHP_CMD_UART)
        |=> (uart_mode_out && s.ack_pend && s.ack_byte == `MHP_ACK && rx_push) ##1 isa_irq_out)
        else $error("Mode change or acknowledge missing.");
    AST_TX_START: assert property (@(posedge clock_in) disable iff (!rstn_in)
        tx_pop |=> !midi_serial_out [*8])
        else $error("Start bit not driven low.");
endmodule // mhp_midi_port
`default_nettype wire

/* File: dv/mhp_midi_dev.sv */
`default_nettype none
// Instrument on the serial line: sends frames on request, decodes what it hears.
module mhp_midi_dev #(
    parameter int BIT_CYC = 32
) (
    input  wire logic clock_in,
    input  wire logic line_in,
    output logic      line_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rx_q[$];
    logic       frame_err = 1'b0;

    // --------------------------------------------------------------
    // Transmit side
    // --------------------------------------------------------------
    // The line idles high, as a real opto-coupled input would leave it.
    initial line_out = 1'b1;

    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out = f[i];
            repeat (BIT_CYC) @(negedge clock_in);
        end
    endtask

    // --------------------------------------------------------------
    // Receive side
    // --------------------------------------------------------------
    // centre sampling
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge line_in);
            repeat (BIT_CYC / 2) @(posedge clock_in);
            if (line_in !== 1'b0) frame_err = 1'b1;
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge clock_in);
                b[i] = line_in;
            end
            repeat (BIT_CYC) @(posedge clock_in);
            if (line_in !== 1'b1) frame_err = 1'b1;
            rx_q.push_back(b);
        end
    end
endmodule // mhp_midi_dev
`default_nettype wire

/* File: dv/midi_uart_host_port_tb_top.sv */
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module midi_uart_host_port_tb_top
    import mhp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    localparam int          BIT  = 32;
    // conventional base
    // The host side owns the base; the customary address keeps the test realistic.
    localparam logic [9:0]  BASE = 10'h330;
    localparam logic [15:0] A0   = {6'h00, BASE[9:1], 1'b0};
    localparam logic [15:0] A1   = {6'h00, BASE[9:1], 1'b1};
    // Commands that answer with a second byte after the acknowledge.
    localparam logic [7:0]  CMDS [5] = '{8'ha5, 8'hab, 8'hac, 8'had, 8'haf};
    localparam logic [7:0]  RSPS [5] = '{8'h00, 8'h00, 8'h15, 8'h01, 8'h64};
    logic        clock_in = 1'b0;
    logic        rstn_in  = 1'b0;
    logic [15:0] sa       = 16'h0000;
    logic        aen      = 1'b0;
    logic        iow_n    = 1'b1;
    logic        ior_n    = 1'b1;
    logic [7:0]  sd       = 8'h00;
    logic [7:0]  sd_out;
    logic        sd_oe;
    logic        irq;
    logic        ser_out;
    logic        ser_in;
    logic        uart;
    logic [7:0]  q[$];
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc        = 0;

    // Clock at 40 MHz.
    always #12.5 clock_in = ~clock_in;

    // Short bit time keeps whole-FIFO runs cheap.
    mhp_midi_port #(.BIT_CYC(BIT), .TICK_CYC(2), .DEPTH(16)) uut (
        .clock_in(clock_in), .rstn_in(rstn_in), .midi_port_base_in(BASE),
        .isa_sa_in(sa), .isa_aen_in(aen), .isa_iow_n_in(iow_n), .isa_ior_n_in(ior_n),
        .isa_sd_in(sd), .isa_sd_out(sd_out), .isa_sd_oe_out(sd_oe), .isa_irq_out(irq),
        .midi_serial_in(ser_in), .midi_serial_out(ser_out), .uart_mode_out(uart));
    mhp_midi_dev #(.BIT_CYC(BIT)) dev (
        .clock_in(clock_in), .line_in(ser_out), .line_out(ser_in));

    // --------------------------------------------------------------
    // Host bus tasks
    // --------------------------------------------------------------
    // Strobes last five cycles so the two-flop synchronisers always see them.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock_in);
        sa = a;
        sd = d;
        repeat (3) @(negedge clock_in);
        iow_n = 1'b0;
        repeat (5) @(negedge clock_in);
        iow_n = 1'b1;
        repeat (2) @(negedge clock_in);
        sd = ~d;
        repeat (3) @(negedge clock_in);
    endtask

    task automatic rd_io(input logic [15:0] a, output logic [7:0] d);
        @(negedge clock_in);
        sa = a;
        repeat (2) @(negedge clock_in);
        ior_n = 1'b0;
        repeat (5) @(negedge clock_in);
        `CHK(sd_oe, 1'b1)
        d = sd_out;
        ior_n = 1'b1;
        repeat (5) @(negedge clock_in);
        `CHK(sd_oe, 1'b0)
    endtask

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and still ends with the report.
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    initial begin
        logic [7:0] b;
        logic [7:0] c;
        void'($urandom(32'h5f3b));
        repeat (6) @(negedge clock_in);
        rstn_in = 1'b1;
        repeat (3) @(negedge clock_in);
        `CHK({irq, uart, ser_out}, 3'b001)
        rd_io(A1, b);
        `CHK(b[7:6], 2'b10)
        // Unknown command gets one acknowledge and echoes in status.
        c = 8'($urandom_range(8'h3e));
        wr(A1, c);
        `CHK(irq, 1'b1)
        rd_io(A1, b);
        `CHK(b, {2'b00, c[5:0]})
        rd_io(A0, b);
        `CHK(b, 8'hfe)
        `CHK(irq, 1'b0)
        rd_io(A0, b);
        `CHK(b, 8'hfe)
        wr(A0, 8'h55);
        // Aliased address and non-I/O cycle must not reach the port.
        wr(A1 | 16'h0400, 8'h3f);
        aen = 1'b1;
        wr(A1, 8'h3f);
        aen = 1'b0;
        `CHK({uart, irq}, 2'b00)
        wr(A1, 8'h3f);
        `CHK({uart, irq}, 2'b11)
        rd_io(A0, b);
        `CHK(b, 8'hfe)
        // One byte goes to the shifter, sixteen fill the FIFO, the last is dropped.
        for (int i = 0; i < 18; i++) begin
            b = 8'($urandom);
            q.push_back(b);
            wr(A0, b);
        end
        rd_io(A1, b);
        `CHK(b[7:6], 2'b11)
        repeat (18 * 10 * BIT) @(negedge clock_in);
        rd_io(A1, b);
        `CHK(b[7:6], 2'b10)
        `CHK(dev.rx_q.size(), 17)
        for (int i = 0; i < 17; i++) `CHK(dev.rx_q[i], q[i])
        `CHK(dev.frame_err, 1'b0)
        // Seventeen serial bytes with no reads: the newest entry is replaced.
        q.delete();
        for (int i = 0; i < 17; i++) begin
            b = 8'($urandom);
            q.push_back(b);
            dev.send(b);
        end
        repeat (4) @(negedge clock_in);
        `CHK(irq, 1'b1)
        for (int i = 0; i < 16; i++) begin
            rd_io(A0, b);
            `CHK(b, q[(i < 15) ? i : 16])
        end
        c = 8'($urandom_range(8'h3e));
        wr(A1, c);
        rd_io(A1, b);
        `CHK({uart, b}, {3'b110, c[5:0]})
        wr(A1, 8'hff);
        `CHK(uart, 1'b0)
        rd_io(A0, b);
        `CHK(b, 8'hfe)
        // Answering commands queue the acknowledge and then their own byte.
        for (int i = 0; i < 5; i++) begin
            wr(A1, CMDS[i]);
            rd_io(A0, b);
            `CHK(b, 8'hfe)
            rd_io(A0, b);
            `CHK(b, RSPS[i])
        end
        complete_run();
    end
endmodule // midi_uart_host_port_tb_top
`default_nettype wire
